// ### rtl/slit_map.vh
// constants for the subtract, logic, shift and rotate timing decoder
// Behaviour
// - register-register subtract, borrow subtract, and, or, xor: 2 bytes, 3 clocks
// - plain indirect memory with register: 2 bytes, 4 clocks
// - indirect with 8-bit displacement and register: 3 bytes, 6 clocks
// - indirect with 16-bit displacement and register: 4 bytes, 6 clocks
// - auto-increment indirect with register: 2 bytes, 5 clocks, pointer advanced after
// - direct address with register, either direction: 3 bytes, 4 clocks
// - immediate to register: 3 clocks, 3 bytes byte immediate, 4 bytes word
// - immediate to plain indirect: 4 clocks, 3 or 4 bytes
// - immediate to auto-increment indirect: 5 clocks, 3 or 4 bytes
// - immediate to indirect with 8-bit displacement: 6 clocks, 4 or 5 bytes
// - immediate to indirect with 16-bit displacement: 6 clocks, 5 or 6 bytes
// - immediate to direct address: 4 clocks, 4 or 5 bytes
// - invert gives ones complement of a register: 2 bytes, 3 clocks
// - logical right shift by count in source register, zero fill, 2 bytes
// - logical right shift by 4-bit immediate count, 2 bytes
// - leading one align shifts left until msb set, limit from source, 2 bytes
// - plain rotates by 4-bit immediate, carry untouched, 2 bytes
// - carry rotates include carry in loop, 4-bit immediate, 2 bytes
// - shifts take 4 (6 for 32-bit) clocks plus one per further two positions
`ifndef SLIT_MAP_VH
`define SLIT_MAP_VH

// ----------------------------------------
// operation codes
// ----------------------------------------
`define SLIT_OP_SUB 4'h0
`define SLIT_OP_BMINUS 4'h1
`define SLIT_OP_AND 4'h2
`define SLIT_OP_OR 4'h3
`define SLIT_OP_XOR 4'h4
`define SLIT_OP_INVERT 4'h5
`define SLIT_OP_RLS_REG 4'h6
`define SLIT_OP_RLS_IMM 4'h7
`define SLIT_OP_ALIGN 4'h8
`define SLIT_OP_ROTL 4'h9
`define SLIT_OP_ROTR 4'ha
`define SLIT_OP_CROTL 4'hb
`define SLIT_OP_CROTR 4'hc

// ----------------------------------------
// addressing modes of the memory-side operand
// ----------------------------------------
`define SLIT_AM_REG 3'h0
`define SLIT_AM_IND 3'h1
`define SLIT_AM_D8 3'h2
`define SLIT_AM_D16 3'h3
`define SLIT_AM_INC 3'h4
`define SLIT_AM_DIR 3'h5

// ----------------------------------------
// operand sizes
// ----------------------------------------
`define SLIT_SZ_BYTE 2'h0
`define SLIT_SZ_WORD 2'h1
`define SLIT_SZ_DWORD 2'h2

// ----------------------------------------
// lengths in bytes and times in clocks
// ----------------------------------------
`define SLIT_LEN_SHORT 3'h2
`define SLIT_LEN_D8 3'h3
`define SLIT_LEN_D16 3'h4
`define SLIT_LEN_DIR 3'h3
`define SLIT_LEN_IMM_BYTE 3'h1
`define SLIT_LEN_IMM_WORD 3'h2
`define SLIT_CLK_REG 5'h03
`define SLIT_CLK_IND 5'h04
`define SLIT_CLK_DISP 5'h06
`define SLIT_CLK_INC 5'h05
`define SLIT_CLK_DIR 5'h04
`define SLIT_CLK_SHIFT 5'h04
`define SLIT_CLK_SHIFT32 5'h06
`define SLIT_CLK_REJECT 5'h01

`endif

// ### rtl/slit_alu.v
// datapath of the subtract, logic, shift and rotate group
`timescale 1ns/1ns
`include "slit_map.vh"
module slit_alu #(
    parameter DW = 32
) (
    input wire [3:0] op,
    input wire [1:0] sz,
    input wire [DW-1:0] a,
    input wire [DW-1:0] b,
    input wire cin,
    input wire [4:0] cnt,
    output reg [DW-1:0] res,
    output reg cout,
    output reg [4:0] steps
);

reg [DW:0] diff;
reg [DW-1:0] m;
reg [DW-1:0] r;
reg c;
reg nb;
integer tb;
integer i;

always @* begin
    diff = {(DW+1){1'b0}};
    m = {DW{1'b1}};
    tb = DW - 1;
    nb = 1'b0;
    steps = 5'h00;
    if (sz == `SLIT_SZ_BYTE) begin
        m = {{(DW-8){1'b0}}, 8'hff};
        tb = 7;
    end else if (sz == `SLIT_SZ_WORD) begin
        m = {{(DW-16){1'b0}}, 16'hffff};
        tb = 15;
    end
    r = a & m;
    c = cin;
    case (op)
        `SLIT_OP_SUB, `SLIT_OP_BMINUS: begin
            // plain subtract ignores the incoming carry
            diff = {1'b0, r} - {1'b0, b & m}
                - {{DW{1'b0}}, (op == `SLIT_OP_BMINUS) & cin};
            r = diff[DW-1:0] & m;
            c = diff[tb+1];
        end
        `SLIT_OP_AND: r = r & b;
        `SLIT_OP_OR: r = r | (b & m);
        `SLIT_OP_XOR: r = r ^ (b & m);
        `SLIT_OP_INVERT: r = ~r & m;
        default: begin
            // one position per pass keeps every size on the same loop
            for (i = 0; i < 31; i = i + 1) begin
                if (i < cnt) begin
                    case (op)
                        `SLIT_OP_RLS_REG, `SLIT_OP_RLS_IMM: begin
                            c = r[0];
                            r = r >> 1;
                        end
                        `SLIT_OP_ALIGN: begin
                            if (!r[tb] && r != {DW{1'b0}}) begin
                                r = (r << 1) & m;
                                steps = steps + 5'h01;
                            end
                        end
                        `SLIT_OP_ROTL: r = ((r << 1) | (r >> tb)) & m;
                        `SLIT_OP_ROTR: r = ((r >> 1) | (r << tb)) & m;
                        `SLIT_OP_CROTL: begin
                            nb = r[tb];
                            r = ((r << 1) | {{(DW-1){1'b0}}, c}) & m;
                            c = nb;
                        end
                        `SLIT_OP_CROTR: begin
                            nb = r[0];
                            r = ((r >> 1) | ({{(DW-1){1'b0}}, c} << tb)) & m;
                            c = nb;
                        end
                        default: r = r;
                    endcase
                end
            end
        end
    endcase
    res = r;
    cout = c;
end

endmodule

// ### rtl/slit_core.v
// instruction length and clock timing for the subtract, logic and shift group
`timescale 1ns/1ns
`include "slit_map.vh"
module slit_core #(
    parameter DW = 32,
    parameter AW = 24
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [3:0] op,
    input wire [2:0] mode,
    input wire mem_is_dst,
    input wire src_imm,
    input wire imm_word,
    input wire [1:0] sz,
    input wire [DW-1:0] dst_val,
    input wire [DW-1:0] src_reg,
    input wire [15:0] imm_val,
    input wire [DW-1:0] mem_val,
    input wire carry_in,
    input wire [AW-1:0] ptr_val,
    output reg busy_r,
    output reg done_r,
    output reg reject_r,
    output reg [2:0] len_r,
    output reg [4:0] clocks_r,
    output reg [DW-1:0] result_r,
    output reg carry_r,
    output reg wr_reg_r,
    output reg wr_mem_r,
    output reg ptr_wr_r,
    output reg [AW-1:0] ptr_nxt_r
);

// ----------------------------------------
// decode helpers
// ----------------------------------------
function [2:0] f_len_base;
    input [2:0] am;
    begin
        case (am)
            `SLIT_AM_REG: f_len_base = `SLIT_LEN_SHORT;
            `SLIT_AM_IND: f_len_base = `SLIT_LEN_SHORT;
            `SLIT_AM_D8: f_len_base = `SLIT_LEN_D8;
            `SLIT_AM_D16: f_len_base = `SLIT_LEN_D16;
            `SLIT_AM_INC: f_len_base = `SLIT_LEN_SHORT;
            `SLIT_AM_DIR: f_len_base = `SLIT_LEN_DIR;
            default: f_len_base = `SLIT_LEN_SHORT;
        endcase
    end
endfunction

function [4:0] f_clk_base;
    input [2:0] am;
    begin
        case (am)
            `SLIT_AM_REG: f_clk_base = `SLIT_CLK_REG;
            `SLIT_AM_IND: f_clk_base = `SLIT_CLK_IND;
            `SLIT_AM_D8: f_clk_base = `SLIT_CLK_DISP;
            `SLIT_AM_D16: f_clk_base = `SLIT_CLK_DISP;
            `SLIT_AM_INC: f_clk_base = `SLIT_CLK_INC;
            `SLIT_AM_DIR: f_clk_base = `SLIT_CLK_DIR;
            default: f_clk_base = `SLIT_CLK_REG;
        endcase
    end
endfunction

function f_is_two_op;
    input [3:0] o;
    begin
        f_is_two_op = (o == `SLIT_OP_SUB) || (o == `SLIT_OP_BMINUS)
            || (o == `SLIT_OP_AND) || (o == `SLIT_OP_OR)
            || (o == `SLIT_OP_XOR);
    end
endfunction

function f_is_shift;
    input [3:0] o;
    begin
        f_is_shift = (o >= `SLIT_OP_RLS_REG) && (o <= `SLIT_OP_CROTR);
    end
endfunction

function f_cnt_from_src;
    input [3:0] o;
    begin
        f_cnt_from_src = (o == `SLIT_OP_RLS_REG) || (o == `SLIT_OP_ALIGN);
    end
endfunction

// ----------------------------------------
// operand selection
// ----------------------------------------
wire mem_form;
wire mem_dst;
wire [DW-1:0] imm_ext;
reg [DW-1:0] opa;
reg [DW-1:0] opb;
wire [4:0] shift_cnt;
wire [DW-1:0] alu_res;
wire alu_cout;
wire [4:0] alu_steps;

assign mem_form = (mode != `SLIT_AM_REG);
// with an immediate source the addressed operand is always the destination
assign mem_dst = mem_form && (src_imm || mem_is_dst);
assign imm_ext = imm_word ? {{(DW-16){1'b0}}, imm_val}
                          : {{(DW-8){1'b0}}, imm_val[7:0]};
assign shift_cnt = f_cnt_from_src(op) ? src_reg[4:0] : {1'b0, imm_val[3:0]};

always @* begin
    opa = dst_val;
    opb = src_reg;
    if (mem_dst) begin
        opa = mem_val;
    end
    if (src_imm) begin
        opb = imm_ext;
    end else if (mem_form && !mem_is_dst) begin
        opb = mem_val;
    end
end

slit_alu #(
    .DW(DW)
) u_alu (
    .op(op),
    .sz(sz),
    .a(opa),
    .b(opb),
    .cin(carry_in),
    .cnt(shift_cnt),
    .res(alu_res),
    .cout(alu_cout),
    .steps(alu_steps)
);

// ----------------------------------------
// length and timing decode
// ----------------------------------------
reg legal;
reg [2:0] len_nxt;
reg [4:0] clk_nxt;
reg [4:0] extra;

always @* begin
    legal = 1'b0;
    len_nxt = `SLIT_LEN_SHORT;
    clk_nxt = `SLIT_CLK_REJECT;
    extra = (op == `SLIT_OP_ALIGN) ? alu_steps : shift_cnt;
    if (f_is_two_op(op)) begin
        legal = (mode <= `SLIT_AM_DIR) && (sz != `SLIT_SZ_DWORD);
        len_nxt = f_len_base(mode);
        if (src_imm) begin
            len_nxt = f_len_base(mode)
                + (imm_word ? `SLIT_LEN_IMM_WORD : `SLIT_LEN_IMM_BYTE);
        end
        clk_nxt = f_clk_base(mode);
    end else if (op == `SLIT_OP_INVERT) begin
        legal = (mode == `SLIT_AM_REG) && !src_imm && (sz != `SLIT_SZ_DWORD);
        len_nxt = `SLIT_LEN_SHORT;
        clk_nxt = `SLIT_CLK_REG;
    end else if (f_is_shift(op)) begin
        legal = (mode == `SLIT_AM_REG) && !src_imm && (sz <= `SLIT_SZ_DWORD);
        len_nxt = `SLIT_LEN_SHORT;
        // one extra clock for each further pair of positions
        if (sz == `SLIT_SZ_DWORD) begin
            clk_nxt = `SLIT_CLK_SHIFT32 + {1'b0, extra[4:1]};
        end else begin
            clk_nxt = `SLIT_CLK_SHIFT + {1'b0, extra[4:1]};
        end
    end
    if (!legal) begin
        clk_nxt = `SLIT_CLK_REJECT;
    end
end

// ----------------------------------------
// held results of the accepted instruction
// ----------------------------------------
// operands are only sampled with start, so the bus may move on afterwards
reg [DW-1:0] hold_res_r;
reg hold_carry_r;
reg hold_mem_r;
reg hold_inc_r;
reg [AW-1:0] hold_ptr_r;
reg hold_legal_r;
reg [4:0] cnt_r;
reg [AW-1:0] step_sz;

always @* begin
    case (sz)
        `SLIT_SZ_BYTE: step_sz = {{(AW-1){1'b0}}, 1'b1};
        `SLIT_SZ_WORD: step_sz = {{(AW-2){1'b0}}, 2'h2};
        default: step_sz = {{(AW-3){1'b0}}, 3'h4};
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        hold_res_r <= {DW{1'b0}};
        hold_carry_r <= 1'b0;
        hold_mem_r <= 1'b0;
        hold_inc_r <= 1'b0;
        hold_ptr_r <= {AW{1'b0}};
        hold_legal_r <= 1'b0;
    end else if (start && !busy_r) begin
        hold_res_r <= alu_res;
        // logic ops leave the carry alone
        hold_carry_r <= (f_is_two_op(op) && op > `SLIT_OP_BMINUS)
                        || op == `SLIT_OP_INVERT ? carry_in : alu_cout;
        hold_mem_r <= mem_dst;
        hold_inc_r <= legal && (mode == `SLIT_AM_INC);
        hold_ptr_r <= ptr_val + step_sz;
        hold_legal_r <= legal;
    end
end

// ----------------------------------------
// clock counter and completion
// ----------------------------------------
always @(posedge clk) begin
    if (rst) begin
        busy_r <= 1'b0;
        done_r <= 1'b0;
        reject_r <= 1'b0;
        cnt_r <= 5'h00;
        len_r <= 3'h0;
        clocks_r <= 5'h00;
        result_r <= {DW{1'b0}};
        carry_r <= 1'b0;
        wr_reg_r <= 1'b0;
        wr_mem_r <= 1'b0;
        ptr_wr_r <= 1'b0;
        ptr_nxt_r <= {AW{1'b0}};
    end else begin
        done_r <= 1'b0;
        reject_r <= 1'b0;
        wr_reg_r <= 1'b0;
        wr_mem_r <= 1'b0;
        ptr_wr_r <= 1'b0;
        if (!busy_r) begin
            if (start) begin
                busy_r <= 1'b1;
                cnt_r <= clk_nxt;
                len_r <= len_nxt;
                clocks_r <= clk_nxt;
            end
        end else if (cnt_r == 5'h01) begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            done_r <= 1'b1;
            if (hold_legal_r) begin
                result_r <= hold_res_r;
                carry_r <= hold_carry_r;
                // only the destination is written
                wr_reg_r <= !hold_mem_r;
                wr_mem_r <= hold_mem_r;
                // pointer moves after the access, in the completion cycle
                ptr_wr_r <= hold_inc_r;
                ptr_nxt_r <= hold_ptr_r;
            end else begin
                reject_r <= 1'b1;
            end
        end else begin
            cnt_r <= cnt_r - 5'h01;
        end
    end
end

endmodule

// ### sim/slit_core_sva.sv
// assertion checker for the instruction timing block
`timescale 1ns/1ns
module slit_core_sva #(
    parameter DW = 32,
    parameter AW = 24
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [3:0] op,
    input wire [2:0] mode,
    input wire mem_is_dst,
    input wire src_imm,
    input wire imm_word,
    input wire [1:0] sz,
    input wire [DW-1:0] dst_val,
    input wire [DW-1:0] src_reg,
    input wire [15:0] imm_val,
    input wire [DW-1:0] mem_val,
    input wire carry_in,
    input wire [AW-1:0] ptr_val,
    input wire busy_r,
    input wire done_r,
    input wire reject_r,
    input wire [2:0] len_r,
    input wire [4:0] clocks_r,
    input wire [DW-1:0] result_r,
    input wire carry_r,
    input wire wr_reg_r,
    input wire wr_mem_r,
    input wire ptr_wr_r,
    input wire [AW-1:0] ptr_nxt_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // cycles since the taking edge
    // ----------------------------------------
    logic [4:0] cyc_r;
    always @(posedge clk) begin
        if (rst) cyc_r <= 5'h00;
        else if (start && !busy_r) cyc_r <= 5'h00;
        else if (busy_r) cyc_r <= cyc_r + 5'h01;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_take_busy: assert property (start && !busy_r |=> busy_r)
        else $error("take did not raise busy");
    chk_done_time: assert property (done_r |-> cyc_r == clocks_r)
        else $error("done not after counted clocks");
    chk_busy_end: assert property ($fell(busy_r) |-> done_r)
        else $error("busy fell without done");
    chk_done_idle: assert property (done_r |-> !busy_r)
        else $error("busy still high at done");
    chk_busy_ignore: assert property (busy_r |=> $stable(len_r) && $stable(clocks_r))
        else $error("start taken while busy");
    chk_reject_pair: assert property (reject_r |-> done_r && clocks_r == 5'h01
        && !(wr_reg_r || wr_mem_r || ptr_wr_r))
        else $error("bad reject pulse");
    chk_write_pulse: assert property ((wr_reg_r || wr_mem_r || ptr_wr_r) |->
        done_r && !(wr_reg_r && wr_mem_r))
        else $error("write outside done or to both");
    chk_result_hold: assert property ($changed(result_r) |-> done_r && !reject_r)
        else $error("result changed outside done");
    chk_len_range: assert property (done_r && !reject_r |-> len_r >= 3'h2 && len_r <= 3'h6)
        else $error("length out of range");
    chk_clk_floor: assert property (done_r && !reject_r |-> clocks_r >= 5'h03)
        else $error("too few clocks");
    cover property (reject_r);
    cover property (ptr_wr_r);
    cover property (wr_mem_r);
    cover property (done_r && clocks_r == 5'h15);
endmodule

bind slit_core slit_core_sva #(.DW(DW), .AW(AW)) u_chk (.clk(clk), .rst(rst), .start(start),
    .op(op), .mode(mode), .mem_is_dst(mem_is_dst), .src_imm(src_imm), .imm_word(imm_word),
    .sz(sz), .dst_val(dst_val), .src_reg(src_reg), .imm_val(imm_val), .mem_val(mem_val),
    .carry_in(carry_in), .ptr_val(ptr_val), .busy_r(busy_r), .done_r(done_r),
    .reject_r(reject_r), .len_r(len_r), .clocks_r(clocks_r), .result_r(result_r),
    .carry_r(carry_r), .wr_reg_r(wr_reg_r), .wr_mem_r(wr_mem_r), .ptr_wr_r(ptr_wr_r),
    .ptr_nxt_r(ptr_nxt_r));

// ### sim/slit_core_bench.sv
// self-checking bench for the instruction timing block
`timescale 1ns/1ns
`include "slit_map.vh"
module slit_core_bench;
    logic clk = 0, rst = 1, start = 0, mem_is_dst = 0, src_imm = 0, imm_word = 0, carry_in = 0;
    logic [3:0] op = 0;
    logic [2:0] mode = 0;
    logic [1:0] sz = `SLIT_SZ_WORD;
    logic [31:0] dst_val = 0, src_reg = 0, mem_val = 0;
    logic [15:0] imm_val = 0;
    logic [23:0] ptr_val = 24'h000100;
    wire busy_r, done_r, reject_r, carry_r, wr_reg_r, wr_mem_r, ptr_wr_r;
    wire [2:0] len_r;
    wire [4:0] clocks_r;
    wire [31:0] result_r;
    wire [23:0] ptr_nxt_r;
    int fails = 0, checks_done = 0;
    int mlen[6] = '{2, 2, 3, 4, 2, 3};
    int mclk[6] = '{3, 4, 6, 6, 5, 4};
    always #50 clk = ~clk;
    slit_core #(.DW(32), .AW(24)) dut (.clk(clk), .rst(rst), .start(start), .op(op),
        .mode(mode), .mem_is_dst(mem_is_dst), .src_imm(src_imm), .imm_word(imm_word), .sz(sz),
        .dst_val(dst_val), .src_reg(src_reg), .imm_val(imm_val), .mem_val(mem_val),
        .carry_in(carry_in), .ptr_val(ptr_val), .busy_r(busy_r), .done_r(done_r),
        .reject_r(reject_r), .len_r(len_r), .clocks_r(clocks_r), .result_r(result_r),
        .carry_r(carry_r), .wr_reg_r(wr_reg_r), .wr_mem_r(wr_mem_r), .ptr_wr_r(ptr_wr_r),
        .ptr_nxt_r(ptr_nxt_r));
    task give_verdict;
        $display("checks %0d, fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // called at a falling edge; returns at the falling edge of the done cycle
    task run(input [3:0] o, input [2:0] m, input d, input [31:0] a, input [31:0] b,
        input int el, input int ec);
        int n;
        op = o; mode = m; mem_is_dst = d; dst_val = a; src_reg = b; start = 1;
        @(negedge clk);
        start = 0;
        // cycles counted from the taking edge, so done lands at n equal to the clock count
        n = 0;
        while (done_r !== 1'b1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        chk(done_r === 1'b1 && n == ec && clocks_r === ec[4:0], "done timing");
        if (el != 0) chk(len_r === el[2:0], "length");
        if (n >= 30) give_verdict();
    endtask
    task t_modes;
        bit md;
        src_imm = 0;
        for (int o = 0; o < 5; o++) for (int m = 0; m < 6; m++) for (int d = 0; d < 2; d++) begin
            md = m != 0 && d == 1;
            run(o[3:0], m[2:0], d[0], 0, 0, mlen[m], mclk[m]);
            if (m == 5) chk(len_r === 3'h3 && clocks_r === 5'h04, "direct form");
            chk(wr_mem_r === md && wr_reg_r === !md, "write target");
            chk(ptr_wr_r === (m == 4), "pointer write");
            if (m == 4) chk(ptr_nxt_r === 24'h000102, "pointer step");
        end
    endtask
    task t_imm;
        logic [3:0] op_pick;
        int el;
        src_imm = 1;
        for (int m = 0; m < 6; m++) for (int w = 0; w < 2; w++) begin
            imm_word = w[0];
            op_pick = m[0] ? `SLIT_OP_XOR : `SLIT_OP_SUB;
            el = mlen[m] + 1 + w;
            run(op_pick, m[2:0], 0, 0, 0, el, mclk[m]);
            chk(wr_mem_r === (m != 0), "immediate dest");
        end
        imm_val = 16'h1234;
        imm_word = 0;
        run(`SLIT_OP_XOR, 0, 0, 32'h00ff, 0, 3, 3);
        chk(result_r[15:0] === 16'h00cb, "byte immediate value");
        imm_word = 1;
        run(`SLIT_OP_XOR, 0, 0, 32'h00ff, 0, 4, 3);
        chk(result_r[15:0] === 16'h12cb, "word immediate value");
        src_imm = 0;
    endtask
    task t_sub;
        carry_in = 1;
        run(`SLIT_OP_SUB, 0, 0, 32'h5, 32'h3, 2, 3);
        chk(result_r[15:0] === 16'h0002 && carry_r === 1'b0, "sub ignores carry");
        run(`SLIT_OP_BMINUS, 0, 0, 32'h5, 32'h3, 2, 3);
        chk(result_r[15:0] === 16'h0001, "borrow subtract");
        carry_in = 0;
        run(`SLIT_OP_SUB, 0, 0, 32'h3, 32'h5, 2, 3);
        chk(result_r[15:0] === 16'hfffe && carry_r === 1'b1, "borrow out");
        mem_val = 32'h9;
        run(`SLIT_OP_SUB, `SLIT_AM_IND, 0, 32'hc, 32'h1, 2, 4);
        chk(result_r[15:0] === 16'h0003 && wr_reg_r === 1'b1, "memory source");
        run(`SLIT_OP_SUB, `SLIT_AM_IND, 1, 32'hc, 32'h1, 2, 4);
        chk(result_r[15:0] === 16'h0008 && wr_mem_r === 1'b1, "memory destination");
        run(`SLIT_OP_XOR, 0, 0, 32'h00ff, 32'h0f0f, 2, 3);
        chk(result_r[15:0] === 16'h0ff0, "xor value");
        run(`SLIT_OP_INVERT, 0, 0, 32'h00ff, 0, 2, 3);
        chk(result_r[15:0] === 16'hff00, "invert value");
    endtask
    task t_shift;
        run(`SLIT_OP_RLS_REG, 0, 0, 32'h00f0, 32'h5, 2, 6);
        chk(result_r[15:0] === 16'h0007, "shift by register");
        imm_val = 16'h000f;
        run(`SLIT_OP_RLS_IMM, 0, 0, 32'hffff, 0, 2, 11);
        chk(result_r[15:0] === 16'h0001, "shift by immediate");
        run(`SLIT_OP_ALIGN, 0, 0, 32'h0010, 32'hf, 2, 9);
        chk(result_r[15:0] === 16'h8000, "align");
        sz = `SLIT_SZ_DWORD;
        run(`SLIT_OP_RLS_REG, 0, 0, 32'h80000000, 32'h1f, 2, 21);
        chk(result_r === 32'h1, "long shift");
        sz = `SLIT_SZ_WORD;
        imm_val = 16'h0001;
        run(`SLIT_OP_ROTL, 0, 0, 32'h8001, 0, 2, 4);
        chk(result_r[15:0] === 16'h0003, "rotate left");
        run(`SLIT_OP_ROTR, 0, 0, 32'h8001, 0, 2, 4);
        chk(result_r[15:0] === 16'hc000, "rotate right");
        run(`SLIT_OP_CROTL, 0, 0, 32'h8000, 0, 2, 4);
        chk(result_r[15:0] === 16'h0000 && carry_r === 1'b1, "carry rotate left");
        carry_in = 1;
        run(`SLIT_OP_CROTR, 0, 0, 32'h0001, 0, 2, 4);
        chk(result_r[15:0] === 16'h8000 && carry_r === 1'b1, "carry rotate right");
    endtask
    task t_reject;
        logic [31:0] keep;
        keep = result_r;
        run(4'hd, 0, 0, 32'h1, 32'h1, 0, 1);
        chk(reject_r === 1'b1 && wr_reg_r === 1'b0, "bad op refused");
        mode = 3'h6;
        run(`SLIT_OP_SUB, 3'h6, 1, 32'h1, 32'h1, 0, 1);
        chk(reject_r === 1'b1 && wr_mem_r === 1'b0, "bad mode refused");
        sz = `SLIT_SZ_DWORD;
        run(`SLIT_OP_AND, 0, 0, 32'h1, 32'h1, 0, 1);
        chk(reject_r === 1'b1 && result_r === keep, "long logic refused");
        sz = `SLIT_SZ_WORD;
        // a second request while busy must be ignored
        op = `SLIT_OP_SUB;
        mode = `SLIT_AM_REG;
        start = 1;
        @(negedge clk);
        op = 4'hd;
        @(negedge clk);
        start = 0;
        repeat (2) @(negedge clk);
        chk(done_r === 1'b1 && reject_r === 1'b0 && clocks_r === 5'h03, "start while busy");
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        @(negedge clk);
        chk(busy_r === 1'b0 && done_r === 1'b0 && result_r === 32'h0, "reset state");
        t_modes;
        t_imm;
        t_sub;
        t_shift;
        t_reject;
        give_verdict;
    end
endmodule
